// ===== hw/event_channel_security_pkg.sv
// Constants shared by the event channel security filter
`default_nettype none

package event_channel_security_pkg;

    // Address windows of the protection unit and the channel controller
    localparam logic [31:0] PU_BASE          = 32'h50003000;
    localparam logic [31:0] CTRL_NS_BASE     = 32'h4001f000;
    localparam logic [31:0] CTRL_S_BASE      = 32'h5001f000;
    localparam logic [3:0]  SECURE_WINDOW    = 4'h5;

    // Protection unit register offsets
    localparam logic [11:0] OFS_DOMAIN_PERM  = 12'h440;
    localparam logic [11:0] OFS_CHANNEL_PERM = 12'h480;

    // Channel controller register offsets
    localparam logic [11:0] OFS_TASK_GROUP   = 12'h000;
    localparam logic [11:0] OFS_SUB_GROUP    = 12'h080;
    localparam logic [11:0] OFS_CHAN_EN      = 12'h500;
    localparam logic [11:0] OFS_CHAN_EN_SET  = 12'h504;
    localparam logic [11:0] OFS_CHAN_EN_CLR  = 12'h508;
    localparam logic [11:0] OFS_GROUP_MEMBER = 12'h800;
    localparam int          GROUP_STRIDE     = 8;
    localparam int          DISABLE_OFS      = 4;
    localparam int          WORD_STRIDE      = 4;

    // Field positions
    localparam int          SUB_ENABLE_BIT   = 31;
    localparam int          TASK_TRIGGER_BIT = 0;
    localparam int          DOMAIN_SEC_BIT   = 4;

    // Reset values
    localparam logic [31:0] PERM_RESET       = 32'hffffffff;
    localparam logic [31:0] CHAN_EN_RESET    = 32'h00000000;
    localparam logic [31:0] MEMBER_RESET     = 32'h00000000;
    localparam logic        DOMAIN_RESET     = 1'b0;

    // Domain that is fixed non-secure
    localparam int          MODEM_DOMAIN     = 0;

    // Security identifier allocation
    localparam logic [7:0]  FLASH_ID_BASE    = 8'h00;
    localparam logic [7:0]  RAM_ID_BASE      = 8'h40;
    localparam logic [7:0]  NS_PERIPH_ID     = 8'hfd;
    localparam logic [7:0]  S_PERIPH_ID      = 8'hfe;

    typedef enum logic [1:0] {
        REGION_FLASH     = 2'b00,
        REGION_RAM       = 2'b01,
        REGION_PERIPH_NS = 2'b10,
        REGION_PERIPH_S  = 2'b11
    } region_kind_t;

endpackage

`default_nettype wire

// ===== hw/event_channel_security_filter.sv
// Security filter for event channels, channel controller and domain attributes
//
// Summary of operation
// R1: A set permission bit makes the matching event channel secure.
// R2: Only secure peripherals publish to or receive tasks from secure channels.
// R3: Non-secure publishes toward a secure channel are dropped without effect.
// R4: Non-secure subscribers never receive events from a secure channel.
// R5: Blocked publishes or subscriptions raise no error, flag or fault.
// R6: Non-secure transfers configure only non-secure channels; secure ones configure all (here only through the secure window, not at 0x4001f000).
// R7: A group is secure when any member channel is secure, enabled or not.
// R8: Non-secure access to secure-channel registers or fields: writes dropped, reads zero.
// R9: No fault or exception for such blocked non-secure accesses.
// R10: Non-secure writes to enable, set, clear leave secure-channel bits unchanged.
// R11: Non-secure reads of enable, set, clear show zero in secure-channel bits.
// R12: Non-secure group enable or disable task writes ignored for secure groups.
// R13: Membership register of a secure group reachable only by secure transfers.
// R14: Secure group ignores subscribed events arriving on non-secure channels.
// R15: Secure channel events trigger both secure and non-secure group tasks.
// R16: External domain transfers carry the attribute from their permission setting.
// R17: Modem domain is always non-secure and has no permission register.
// R18: Flash IDs equal index, RAM from 64, peripherals 253 and 254.
// R19: Protection unit registers sit only in the secure window at 0x50003000.
// R20: Security checks act combinationally, adding no latency to permitted traffic.
//
// Added by the designer: strobed register access and the address map.
`default_nettype none

module event_channel_security_filter
    import event_channel_security_pkg::*;
#(
    parameter int NUM_CHANNELS    = 32,
    parameter int NUM_GROUPS      = 6,
    parameter int NUM_PUBLISHERS  = 4,
    parameter int NUM_SUBSCRIBERS = 4,
    parameter int NUM_DOMAINS     = 2,
    parameter int CH_IDX_W        = $clog2(NUM_CHANNELS)
) (
    input  wire logic                                          clk_sys,
    input  wire logic                                          rstn,
    // Register port
    input  wire logic [31:0]                                   regAddr,
    input  wire logic [31:0]                                   regWData,
    input  wire logic                                          regWrite,
    input  wire logic                                          regRead,
    input  wire logic                                          regSecure,
    output logic      [31:0]                                   regRData,
    // Event publishers
    input  wire logic [NUM_PUBLISHERS-1:0]                     pubEvent,
    input  wire logic [NUM_PUBLISHERS-1:0][CH_IDX_W-1:0]       pubChan,
    input  wire logic [NUM_PUBLISHERS-1:0]                     pubSecure,
    // Task subscribers
    input  wire logic [NUM_SUBSCRIBERS-1:0]                    subEnable,
    input  wire logic [NUM_SUBSCRIBERS-1:0][CH_IDX_W-1:0]      subChan,
    input  wire logic [NUM_SUBSCRIBERS-1:0]                    subSecure,
    output logic      [NUM_SUBSCRIBERS-1:0]                    subTask,
    // Channel activity and group state
    output logic      [NUM_CHANNELS-1:0]                       chanFire,
    output logic      [NUM_CHANNELS-1:0]                       chanEnable,
    output logic      [NUM_GROUPS-1:0]                         groupSecure,
    // External domain attributes
    output logic      [NUM_DOMAINS-1:0]                        domainSecure,
    // Security identifier lookup
    input  wire region_kind_t                                  idKind,
    input  wire logic [5:0]                                    idIndex,
    output logic      [7:0]                                    idValue
);

    // Register state
    logic [NUM_CHANNELS-1:0]                 chanSecure_q, chanSecure_d;
    logic [NUM_CHANNELS-1:0]                 chanEnable_q, chanEnable_d;
    logic [NUM_GROUPS-1:0][NUM_CHANNELS-1:0] member_q, member_d;
    logic [NUM_GROUPS-1:0]                   subEnOn_q, subEnOn_d;
    logic [NUM_GROUPS-1:0][CH_IDX_W-1:0]     subEnChan_q, subEnChan_d;
    logic [NUM_GROUPS-1:0]                   subDisOn_q, subDisOn_d;
    logic [NUM_GROUPS-1:0][CH_IDX_W-1:0]     subDisChan_q, subDisChan_d;
    logic [NUM_DOMAINS-1:0]                  domainSec_q, domainSec_d;
    logic [31:0]                             rdata_q, rdata_d;

    // Decode helpers
    logic        inSecureWindow;
    logic        secView;
    logic        blocked;
    logic        puHit;
    logic        ctrlHit;
    logic [11:0] offset;
    logic [NUM_GROUPS-1:0] enTrig;
    logic [NUM_GROUPS-1:0] disTrig;

    // Address windows and the security view of the access
    always_comb begin
        offset         = regAddr[11:0];
        inSecureWindow = (regAddr[31:28] == SECURE_WINDOW);
        secView        = regSecure && inSecureWindow;
        blocked        = !regSecure && inSecureWindow;           // R9
        puHit          = (regAddr[31:12] == PU_BASE[31:12]);        // R19
        ctrlHit        = (regAddr[31:12] == CTRL_NS_BASE[31:12]) ||
                         (regAddr[31:12] == CTRL_S_BASE[31:12]);
    end

    // Channel publish filter
    always_comb begin
        chanFire = '0;
        for (int c = 0; c < NUM_CHANNELS; c++) begin
            for (int p = 0; p < NUM_PUBLISHERS; p++) begin
                if (pubEvent[p] && (int'(pubChan[p]) == c) &&
                    (pubSecure[p] || !chanSecure_q[c])) begin     // R1 R2 R3 R20
                    chanFire[c] = chanEnable_q[c];
                end
            end
        end
    end

    // Subscriber delivery filter, silent when blocked
    always_comb begin
        for (int s = 0; s < NUM_SUBSCRIBERS; s++) begin
            subTask[s] = subEnable[s] && chanFire[subChan[s]] &&
                         (subSecure[s] || !chanSecure_q[subChan[s]]); // R2 R4 R5 R20
        end
    end

    // Group security and subscribed group triggers
    always_comb begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            groupSecure[g] = |(member_q[g] & chanSecure_q);          // R7
            enTrig[g]  = subEnOn_q[g] && chanFire[subEnChan_q[g]] &&
                         (!groupSecure[g] || chanSecure_q[subEnChan_q[g]]);   // R14 R15
            disTrig[g] = subDisOn_q[g] && chanFire[subDisChan_q[g]] &&
                         (!groupSecure[g] || chanSecure_q[subDisChan_q[g]]);  // R14 R15
        end
    end

    // Next state of all writable registers and the channel enables
    always_comb begin
        logic [NUM_CHANNELS-1:0] wMask;
        logic                    wr;
        wr           = regWrite && !blocked;                         // R9
        // Bits a non-secure view may touch
        wMask = secView ? '1 : ~chanSecure_q;                        // R6
        chanSecure_d = chanSecure_q;
        chanEnable_d = chanEnable_q;
        member_d     = member_q;
        subEnOn_d    = subEnOn_q;
        subEnChan_d  = subEnChan_q;
        subDisOn_d   = subDisOn_q;
        subDisChan_d = subDisChan_q;
        domainSec_d  = domainSec_q;
        // Protection unit registers, secure view only
        if (wr && puHit && secView) begin                            // R19
            if (offset == OFS_CHANNEL_PERM) begin
                chanSecure_d = regWData[NUM_CHANNELS-1:0];           // R1
            end
            for (int n = 0; n < NUM_DOMAINS; n++) begin
                if (n != MODEM_DOMAIN &&
                    offset == 12'(OFS_DOMAIN_PERM + n * WORD_STRIDE)) begin  // R17
                    domainSec_d[n] = regWData[DOMAIN_SEC_BIT];       // R16
                end
            end
        end
        // Channel controller registers
        if (wr && ctrlHit) begin
            if (offset == OFS_CHAN_EN) begin
                chanEnable_d = (chanEnable_q & ~wMask) |
                               (regWData[NUM_CHANNELS-1:0] & wMask); // R10
            end
            if (offset == OFS_CHAN_EN_SET) begin
                chanEnable_d = chanEnable_q | (regWData[NUM_CHANNELS-1:0] & wMask); // R10
            end
            if (offset == OFS_CHAN_EN_CLR) begin
                chanEnable_d = chanEnable_q & ~(regWData[NUM_CHANNELS-1:0] & wMask); // R10
            end
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (secView || !groupSecure[g]) begin                // R8 R13
                    if (offset == 12'(OFS_GROUP_MEMBER + g * WORD_STRIDE)) begin
                        member_d[g] = regWData[NUM_CHANNELS-1:0];    // R13
                    end
                    if (offset == 12'(OFS_SUB_GROUP + g * GROUP_STRIDE)) begin
                        subEnOn_d[g]   = regWData[SUB_ENABLE_BIT];
                        subEnChan_d[g] = regWData[CH_IDX_W-1:0];
                    end
                    if (offset == 12'(OFS_SUB_GROUP + g * GROUP_STRIDE + DISABLE_OFS)) begin
                        subDisOn_d[g]   = regWData[SUB_ENABLE_BIT];
                        subDisChan_d[g] = regWData[CH_IDX_W-1:0];
                    end
                end
            end
        end
        // Group enable tasks, from software or subscribed events
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (enTrig[g] || (wr && ctrlHit && regWData[TASK_TRIGGER_BIT] &&
                (secView || !groupSecure[g]) &&                      // R12
                offset == 12'(OFS_TASK_GROUP + g * GROUP_STRIDE))) begin
                chanEnable_d = chanEnable_d | member_q[g];
            end
        end
        // Group disable tasks win over enables in the same cycle
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (disTrig[g] || (wr && ctrlHit && regWData[TASK_TRIGGER_BIT] &&
                (secView || !groupSecure[g]) &&                      // R12
                offset == 12'(OFS_TASK_GROUP + g * GROUP_STRIDE + DISABLE_OFS))) begin
                chanEnable_d = chanEnable_d & ~member_q[g];
            end
        end
    end

    // Read data, zero for anything hidden from the view
    always_comb begin
        rdata_d = '0;
        if (regRead && !blocked) begin                               // R9
            if (puHit && secView) begin                              // R19
                if (offset == OFS_CHANNEL_PERM) begin
                    rdata_d[NUM_CHANNELS-1:0] = chanSecure_q;
                end
                for (int n = 0; n < NUM_DOMAINS; n++) begin
                    if (n != MODEM_DOMAIN &&
                        offset == 12'(OFS_DOMAIN_PERM + n * WORD_STRIDE)) begin // R17
                        rdata_d[DOMAIN_SEC_BIT] = domainSec_q[n];
                    end
                end
            end
            if (ctrlHit) begin
                if (offset == OFS_CHAN_EN || offset == OFS_CHAN_EN_SET ||
                    offset == OFS_CHAN_EN_CLR) begin
                    rdata_d[NUM_CHANNELS-1:0] = chanEnable_q &
                                                (secView ? '1 : ~chanSecure_q); // R11
                end
                for (int g = 0; g < NUM_GROUPS; g++) begin
                    if (secView || !groupSecure[g]) begin            // R8 R13
                        if (offset == 12'(OFS_GROUP_MEMBER + g * WORD_STRIDE)) begin
                            rdata_d[NUM_CHANNELS-1:0] = member_q[g];
                        end
                        if (offset == 12'(OFS_SUB_GROUP + g * GROUP_STRIDE)) begin
                            rdata_d[SUB_ENABLE_BIT] = subEnOn_q[g];
                            rdata_d[CH_IDX_W-1:0]   = subEnChan_q[g];
                        end
                        if (offset == 12'(OFS_SUB_GROUP + g * GROUP_STRIDE + DISABLE_OFS)) begin
                            rdata_d[SUB_ENABLE_BIT] = subDisOn_q[g];
                            rdata_d[CH_IDX_W-1:0]   = subDisChan_q[g];
                        end
                    end
                end
            end
        end
    end

    // Register all state
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            chanSecure_q <= PERM_RESET[NUM_CHANNELS-1:0];
            chanEnable_q <= CHAN_EN_RESET[NUM_CHANNELS-1:0];
            for (int g = 0; g < NUM_GROUPS; g++) begin
                member_q[g] <= MEMBER_RESET[NUM_CHANNELS-1:0];
            end
            subEnOn_q    <= '0;
            subEnChan_q  <= '0;
            subDisOn_q   <= '0;
            subDisChan_q <= '0;
            domainSec_q  <= {NUM_DOMAINS{DOMAIN_RESET}};
            rdata_q      <= '0;
        end else begin
            chanSecure_q <= chanSecure_d;
            chanEnable_q <= chanEnable_d;
            member_q     <= member_d;
            subEnOn_q    <= subEnOn_d;
            subEnChan_q  <= subEnChan_d;
            subDisOn_q   <= subDisOn_d;
            subDisChan_q <= subDisChan_d;
            domainSec_q  <= domainSec_d;
            rdata_q      <= rdata_d;
        end
    end

    // Domain attributes, modem forced non-secure
    always_comb begin
        domainSecure = domainSec_q;                                  // R16
        domainSecure[MODEM_DOMAIN] = 1'b0;                           // R17
    end

    // Security identifier lookup
    always_comb begin
        unique case (idKind)
            REGION_FLASH:     idValue = FLASH_ID_BASE + {2'b00, idIndex}; // R18
            REGION_RAM:       idValue = RAM_ID_BASE + {2'b00, idIndex};   // R18
            REGION_PERIPH_NS: idValue = NS_PERIPH_ID;                     // R18
            REGION_PERIPH_S:  idValue = S_PERIPH_ID;                      // R18
        endcase
    end

    assign regRData   = rdata_q;
    assign chanEnable = chanEnable_q;

endmodule

`default_nettype wire

// ===== verification/event_channel_security_filter_chk.sv
// Port-level checker for the event channel security filter
`default_nettype none

module event_channel_security_filter_chk
    import event_channel_security_pkg::*;
#(
    parameter int NUM_CHANNELS    = 32,
    parameter int NUM_PUBLISHERS  = 4,
    parameter int NUM_SUBSCRIBERS = 4,
    parameter int NUM_DOMAINS     = 2,
    parameter int CH_IDX_W        = 5
) (
    input wire logic                                     clk_sys,
    input wire logic                                     rstn,
    input wire logic [31:0]                              regAddr,
    input wire logic [31:0]                              regWData,
    input wire logic                                     regWrite,
    input wire logic                                     regRead,
    input wire logic                                     regSecure,
    input wire logic [31:0]                              regRData,
    input wire logic [NUM_PUBLISHERS-1:0]                pubEvent,
    input wire logic [NUM_PUBLISHERS-1:0][CH_IDX_W-1:0]  pubChan,
    input wire logic [NUM_PUBLISHERS-1:0]                pubSecure,
    input wire logic [NUM_SUBSCRIBERS-1:0]               subEnable,
    input wire logic [NUM_SUBSCRIBERS-1:0][CH_IDX_W-1:0] subChan,
    input wire logic [NUM_SUBSCRIBERS-1:0]               subSecure,
    input wire logic [NUM_SUBSCRIBERS-1:0]               subTask,
    input wire logic [NUM_CHANNELS-1:0]                  chanFire,
    input wire logic [NUM_CHANNELS-1:0]                  chanEnable,
    input wire logic [NUM_DOMAINS-1:0]                   domainSecure
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NUM_CHANNELS-1:0]    pubMask;
    logic [NUM_CHANNELS-1:0]    secMask;
    logic [NUM_SUBSCRIBERS-1:0] subHit;

    // Channels hit by any or by secure publishers, subscribers on firing channels
    always_comb begin
        pubMask = '0;
        secMask = '0;
        for (int p = 0; p < NUM_PUBLISHERS; p++) begin
            if (pubEvent[p]) pubMask[pubChan[p]] = 1'b1;
            if (pubEvent[p] && pubSecure[p]) secMask[pubChan[p]] = 1'b1;
        end
        for (int s = 0; s < NUM_SUBSCRIBERS; s++) subHit[s] = subEnable[s] && chanFire[subChan[s]];
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence secSetWr;
        regWrite && regSecure && regAddr == (CTRL_S_BASE + 32'(OFS_CHAN_EN_SET)) && chanFire == '0;
    endsequence
    sequence nsWinWr;
        regWrite && !regSecure && regAddr[31:28] == SECURE_WINDOW && chanFire == '0;
    endsequence
    sequence nsWinRd;
        regRead && !regSecure && regAddr[31:28] == SECURE_WINDOW;
    endsequence

    fire_cause_a: assert property ((chanFire & ~(pubMask & chanEnable)) == '0)
        else $error("channel fired without an enabled publisher");
    sec_pub_a: assert property ((secMask & chanEnable & ~chanFire) == '0)
        else $error("secure publish on enabled channel did not fire");
    task_cause_a: assert property ((subTask & ~subHit) == '0)
        else $error("task without a firing subscribed channel");
    sec_task_a: assert property ((subHit & subSecure & ~subTask) == '0)
        else $error("secure subscriber missed a task");
    modem_ns_a: assert property (domainSecure[MODEM_DOMAIN] == 1'b0)
        else $error("modem domain marked secure");
    rdata_idle_a: assert property (regRData != 32'h0 |-> $past(regRead))
        else $error("read data outside the read answer cycle");
    set_bits_a: assert property (secSetWr |=> (chanEnable & $past(regWData)) == $past(regWData))
        else $error("secure enable-set write lost bits");
    ns_wr_win_a: assert property (nsWinWr |=> $stable(chanEnable) && $stable(domainSecure))
        else $error("non-secure write into secure window took effect");
    ns_rd_win_a: assert property (nsWinRd |=> regRData == 32'h0)
        else $error("non-secure read of secure window not zero");
endmodule

bind event_channel_security_filter event_channel_security_filter_chk #(
    .NUM_CHANNELS(NUM_CHANNELS), .NUM_PUBLISHERS(NUM_PUBLISHERS),
    .NUM_SUBSCRIBERS(NUM_SUBSCRIBERS), .NUM_DOMAINS(NUM_DOMAINS), .CH_IDX_W(CH_IDX_W)
) i_event_channel_security_filter_chk (
    .clk_sys, .rstn, .regAddr, .regWData, .regWrite, .regRead, .regSecure, .regRData,
    .pubEvent, .pubChan, .pubSecure, .subEnable, .subChan, .subSecure, .subTask,
    .chanFire, .chanEnable, .domainSecure
);

`default_nettype wire

// ===== verification/subscriber_model.sv
// Subscribing peripherals with fixed subscriptions and task counters
`default_nettype none

module subscriber_model #(
    parameter int NUM_SUBSCRIBERS = 4,
    parameter int CH_IDX_W        = 5
) (
    input  wire logic                                     clk_sys,
    input  wire logic                                     rstn,
    input  wire logic [NUM_SUBSCRIBERS-1:0]               subTask,
    output logic      [NUM_SUBSCRIBERS-1:0]               subEnable,
    output logic      [NUM_SUBSCRIBERS-1:0][CH_IDX_W-1:0] subChan,
    output logic      [NUM_SUBSCRIBERS-1:0]               subSecure,
    output logic      [NUM_SUBSCRIBERS-1:0][7:0]          taskCount
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [NUM_SUBSCRIBERS-1:0][7:0] taskCount_q;
    logic [NUM_SUBSCRIBERS-1:0][7:0] taskCount_d;

    // Lower half on channel 3, upper half on 5; outermost ones secure
    always_comb begin
        for (int s = 0; s < NUM_SUBSCRIBERS; s++) begin
            subEnable[s] = 1'b1;
            subChan[s] = (s < NUM_SUBSCRIBERS / 2) ? CH_IDX_W'('h3) : CH_IDX_W'('h5);
            subSecure[s] = (s == 0) || (s == NUM_SUBSCRIBERS - 1);
            taskCount_d[s] = taskCount_q[s] + {7'h0, subTask[s]};
        end
    end

    // Count delivered tasks
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) taskCount_q <= '0;
        else taskCount_q <= taskCount_d;
    end
    assign taskCount = taskCount_q;
endmodule

`default_nettype wire

// ===== verification/tb_event_channel_security_filter.sv
// Self-checking bench for the event channel security filter
`default_nettype none

module tb_event_channel_security_filter
    import event_channel_security_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0]  ch;
        logic        sec;
        logic [31:0] fire;
        logic [3:0]  tasks;
    } row_t;
    logic            clk_sys   = 1'b0;
    logic            rstn      = 1'b0;
    logic [31:0]     regAddr   = '0;
    logic [31:0]     regWData  = '0;
    logic            regWrite  = 1'b0;
    logic            regRead   = 1'b0;
    logic            regSecure = 1'b0;
    logic [3:0]      pubEvent  = '0;
    logic [3:0][4:0] pubChan   = '0;
    logic [3:0]      pubSecure = '0;
    region_kind_t    idKind    = REGION_FLASH;
    logic [5:0]      idIndex   = '0;
    logic [31:0]     regRData, chanFire, chanEnable, f;
    logic [3:0]      subEnable, subSecure, subTask, t;
    logic [3:0][4:0] subChan;
    logic [3:0][7:0] taskCount;
    logic [5:0]      groupSecure;
    logic [1:0]      domainSecure;
    logic [7:0]      idValue;
    logic [3:0][7:0] idExp     = {8'hfe, 8'hfd, 8'h4f, 8'h1f};
    int              num_errors  = 0;
    int              checks_done = 0;
    // Channel 3 secure, 3 and 5 enabled, 7 disabled
    row_t            rows [5] = '{'{5'h3, 1'b1, 32'h8, 4'h1}, '{5'h3, 1'b0, 32'h0, 4'h0},
        '{5'h5, 1'b0, 32'h20, 4'hc}, '{5'h5, 1'b1, 32'h20, 4'hc}, '{5'h7, 1'b1, 32'h0, 4'h0}};

    event_channel_security_filter i_event_channel_security_filter (
        .clk_sys, .rstn, .regAddr, .regWData, .regWrite, .regRead, .regSecure, .regRData,
        .pubEvent, .pubChan, .pubSecure, .subEnable, .subChan, .subSecure, .subTask,
        .chanFire, .chanEnable, .groupSecure, .domainSecure, .idKind, .idIndex, .idValue);
    subscriber_model i_subscriber_model (
        .clk_sys, .rstn, .subTask, .subEnable, .subChan, .subSecure, .taskCount);

    always #4 clk_sys = ~clk_sys;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic s);
        @(posedge clk_sys);
        regAddr <= a;
        regWData <= d;
        regSecure <= s;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic s, input logic [31:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regSecure <= s;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        chk("read", regRData, exp);
    endtask
    task automatic pub(input logic [4:0] c, input logic s);
        @(posedge clk_sys);
        pubEvent[0] <= 1'b1;
        pubChan[0] <= c;
        pubSecure[0] <= s;
        @(negedge clk_sys);
        f = chanFire;
        t = subTask;
        @(posedge clk_sys);
        pubEvent[0] <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        @(negedge clk_sys);
        chk("enable", chanEnable, 32'h0);
        chk("domain", {30'h0, domainSecure}, 32'h0);
        rd_chk(32'h50003480, 1'b1, 32'hffffffff);
        wr(32'h50003480, 32'h8, 1'b1);
        wr(32'h5001f504, 32'h28, 1'b1);
        wr(32'h5001f800, 32'h8, 1'b1);
        wr(32'h5001f804, 32'h20, 1'b1);
        chk("group", {26'h0, groupSecure}, 32'h1);
        foreach (rows[i]) begin
            pub(rows[i].ch, rows[i].sec);
            chk("fire", f, rows[i].fire);
            chk("task", {28'h0, t}, {28'h0, rows[i].tasks});
        end
        rd_chk(32'h5001f500, 1'b1, 32'h28);
        rd_chk(32'h4001f500, 1'b0, 32'h20);
        rd_chk(32'h4001f504, 1'b1, 32'h20);
        wr(32'h4001f508, 32'h28, 1'b0);
        chk("clear", chanEnable, 32'h8);
        wr(32'h4001f504, 32'h28, 1'b0);
        chk("set", chanEnable, 32'h28);
        wr(32'h50003480, 32'h0, 1'b0);
        rd_chk(32'h50003480, 1'b1, 32'h8);
        rd_chk(32'h50003480, 1'b0, 32'h0);
        rd_chk(32'h5001f400, 1'b1, 32'h0);
        wr(32'h4001f800, 32'h0, 1'b0);
        rd_chk(32'h5001f800, 1'b1, 32'h8);
        rd_chk(32'h4001f800, 1'b0, 32'h0);
        rd_chk(32'h4001f804, 1'b0, 32'h20);
        wr(32'h4001f004, 32'h1, 1'b0);
        chk("grp dis", chanEnable, 32'h28);
        wr(32'h4001f00c, 32'h1, 1'b0);
        chk("grp dis", chanEnable, 32'h8);
        wr(32'h4001f008, 32'h1, 1'b0);
        chk("grp en", chanEnable, 32'h28);
        wr(32'h5001f084, 32'h80000005, 1'b1);
        pub(5'h5, 1'b0);
        chk("sub ns", chanEnable, 32'h28);
        wr(32'h5001f08c, 32'h80000003, 1'b1);
        pub(5'h3, 1'b1);
        chk("sub s", chanEnable, 32'h8);
        chk("count", taskCount, 32'h03030002);
        wr(32'h50003444, 32'h10, 1'b1);
        wr(32'h50003440, 32'h10, 1'b1);
        chk("domain", {30'h0, domainSecure}, 32'h2);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            idKind <= region_kind_t'(k);
            idIndex <= (k == 0) ? 6'h1f : 6'h0f;
            @(negedge clk_sys);
            chk("id", {24'h0, idValue}, {24'h0, idExp[k]});
        end
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(negedge clk_sys);
        chk("rst enable", chanEnable, 32'h0);
        chk("rst group", {26'h0, groupSecure}, 32'h0);
        @(posedge clk_sys);
        rstn <= 1'b1;
        rd_chk(32'h5001f500, 1'b1, 32'h0);
        wrap_up();
    end
endmodule

`default_nettype wire
